// ==== inc/oor_pkg.sv ====
// oor_pkg: constants, types and helpers of the out-of-range monitor
package oor_pkg;
  localparam int          CH_N        = 4;
  localparam int          RES_W       = 16;
  localparam int          LIM_W       = 12;
  localparam int          FLAG_W      = 10;
  localparam int          IRQ_W       = 3;
  localparam int          ADDR_W      = 12;
  // byte offsets on the bus
  localparam logic [11:0] OFS_FLAGS   = 12'h000;
  localparam logic [11:0] OFS_LOW     = 12'h004;
  localparam logic [11:0] OFS_HIGH    = 12'h008;
  localparam logic [11:0] OFS_CFG     = 12'h00C;
  localparam logic [11:0] OFS_CMD     = 12'h010;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h014;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h018;
  // address nibble carried in bits 15:12 of the flag, limit and configuration registers
  localparam logic [3:0]  TAG_FLAGS   = 4'h3;
  localparam logic [3:0]  TAG_LOW     = 4'h4;
  localparam logic [3:0]  TAG_HIGH    = 4'h5;
  localparam logic [3:0]  TAG_CFG     = 4'h2;
  // limit fields and fills
  localparam logic [11:0] LOW_RST     = 12'h000;
  localparam logic [11:0] HIGH_RST    = 12'hFFF;
  localparam logic [3:0]  LOW_FILL    = 4'h0;
  localparam logic [3:0]  HIGH_FILL   = 4'hF;
  // reset command codes
  localparam logic [7:0]  CMD_SOFT    = 8'h3C;
  localparam logic [7:0]  CMD_HARD    = 8'hFF;
  // configuration fields
  localparam int          CFG_OOR_EN  = 3;
  localparam int          CFG_LANE_LO = 8;
  localparam logic [1:0]  LANE_ONE    = 2'b01;
  localparam logic [1:0]  LANE_RST    = 2'b00;
  localparam logic        OOR_EN_RST  = 1'b0;
  // flag and event bit positions
  localparam int          FL_CRC      = 9;
  localparam int          FL_SETUP    = 8;
  localparam logic [9:0]  FLAGS_RST   = 10'h000;
  localparam int          EV_ALERT    = 0;
  localparam int          EV_CRC      = 1;
  localparam int          EV_SETUP    = 2;

  typedef logic [RES_W-1:0] oor_res_t;

  typedef struct packed {
    logic                       valid;
    logic [CH_N-1:0][RES_W-1:0] value;
  } oor_conv_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DONE = 3'b010,
    ST_HOLD = 3'b100
  } oor_bus_st_t;

  function automatic oor_res_t lim_low(input logic [LIM_W-1:0] f);
    return {f, LOW_FILL};
  endfunction

  function automatic oor_res_t lim_high(input logic [LIM_W-1:0] f);
    return {f, HIGH_FILL};
  endfunction
endpackage

// ==== hw/oor_limit_cmp.sv ====
// oor_limit_cmp: registered per-channel limit comparison
`timescale 1ns/1ps
module oor_limit_cmp #(
  parameter int CH = oor_pkg::CH_N
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              flush,
  input  wire oor_pkg::oor_conv_t conv,
  input  wire oor_pkg::oor_res_t lowInt,
  input  wire oor_pkg::oor_res_t highInt,
  output logic                   hitValid,
  output logic [CH-1:0]          over,
  output logic [CH-1:0]          under
);
  import oor_pkg::*;

  logic [CH-1:0] next_over;
  logic [CH-1:0] next_under;

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      next_over[i]  = conv.value[i] > highInt;
      next_under[i] = conv.value[i] < lowInt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hitValid <= 1'b0;
      over     <= '0;
      under    <= '0;
    end else begin
      hitValid <= conv.valid && !flush;
      over     <= next_over;
      under    <= next_under;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  under_compare_a: assert property (
    conv.valid && !flush && (conv.value[0] < lowInt) |=> hitValid && under[0])
    else $error("result below lower limit not flagged");
  no_under_a: assert property (
    conv.valid && (conv.value[0] > lowInt) |=> !under[0])
    else $error("result above lower limit flagged under");
  over_compare_a: assert property (
    conv.valid && !flush && (conv.value[0] > highInt) |=> hitValid && over[0])
    else $error("result above upper limit not flagged");
  no_over_a: assert property (
    conv.valid && (conv.value[0] < highInt) |=> !over[0])
    else $error("result below upper limit flagged over");
endmodule

// ==== hw/oor_monitor.sv ====
// oor_monitor: four-channel out-of-range monitor with apb registers
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module oor_monitor (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [oor_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire oor_pkg::oor_conv_t    conv,
  input  wire logic                  crcWriteFail,
  input  wire logic                  setupLoadFail,
  input  wire logic                  laneBData,
  output logic                       secondDataOut,
  output logic                       softResetPulse,
  output logic                       setupRestart,
  output logic                       irq
);
  import oor_pkg::*;

  oor_bus_st_t         st;
  oor_bus_st_t         next_st;
  logic [LIM_W-1:0]    lowField;
  logic [LIM_W-1:0]    highField;
  logic [1:0]          laneSel;
  logic                oorEn;
  logic [FLAG_W-1:0]   flags;
  logic [FLAG_W-1:0]   next_flags;
  logic [FLAG_W-1:0]   flagSnap;
  logic [IRQ_W-1:0]    irqStat;
  logic [IRQ_W-1:0]    irqMask;
  logic [IRQ_W-1:0]    next_irqStat;
  logic [31:0]         rdWord;
  logic [7:0]          alertSet;
  logic                hitValid;
  logic [CH_N-1:0]     hitOver;
  logic [CH_N-1:0]     hitUnder;

  // bus decode
  wire busReq   = psel && penable && (st == ST_IDLE);
  wire busAcc   = psel && penable && pready;
  wire hitFlags = paddr == OFS_FLAGS;
  wire hitLow   = paddr == OFS_LOW;
  wire hitHigh  = paddr == OFS_HIGH;
  wire hitCfg   = paddr == OFS_CFG;
  wire hitCmd   = paddr == OFS_CMD;
  wire hitIrqSt = paddr == OFS_IRQ_ST;
  wire hitIrqMk = paddr == OFS_IRQ_MSK;
  wire mapped   = hitFlags | hitLow | hitHigh | hitCfg | hitCmd | hitIrqSt | hitIrqMk;
  wire wrAcc    = busAcc && pwrite && mapped;
  wire rdFlags  = busAcc && !pwrite && hitFlags;
  wire softHit  = wrAcc && hitCmd && (pwdata[7:0] == CMD_SOFT);
  wire hardHit  = wrAcc && hitCmd && (pwdata[7:0] == CMD_HARD);
  wire wrLow    = wrAcc && hitLow;
  wire wrHigh   = wrAcc && hitHigh;
  wire wrCfg    = wrAcc && hitCfg;
  wire wrIrqSt  = wrAcc && hitIrqSt;
  wire wrIrqMk  = wrAcc && hitIrqMk;

  // internal limits
  wire oor_res_t lowInt  = lim_low(lowField);
  wire oor_res_t highInt = lim_high(highField);

  oor_limit_cmp #(
    .CH (CH_N)
  ) u_cmp (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .flush    (softHit || hardHit),
    .conv     (conv),
    .lowInt   (lowInt),
    .highInt  (highInt),
    .hitValid (hitValid),
    .over     (hitOver),
    .under    (hitUnder)
  );

  // channel events in flag layout
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      alertSet[2*i]   = hitValid && hitUnder[i];
      alertSet[2*i+1] = hitValid && hitOver[i];
    end
  end

  // clear sources; a read clears only what it reported
  wire [FLAG_W-1:0] keepSetup = ~(FLAG_W'(1) << FL_SETUP);
  wire [FLAG_W-1:0] rdClr     = rdFlags ? (flagSnap & keepSetup) : '0;
  wire [FLAG_W-1:0] softClr   = softHit ? keepSetup : '0;
  wire [FLAG_W-1:0] hardClr   = hardHit ? '1 : '0;
  wire [FLAG_W-1:0] setBits   = {crcWriteFail, setupLoadFail, alertSet};

  assign next_flags = (flags & ~(rdClr | softClr | hardClr)) | setBits;

  // interrupt events, write one to clear
  wire [IRQ_W-1:0] irqEvt = {setupLoadFail, crcWriteFail, |alertSet};
  wire [IRQ_W-1:0] irqClr = wrIrqSt ? pwdata[IRQ_W-1:0] : '0;
  assign next_irqStat = (irqStat & ~irqClr) | irqEvt;

  // bus state machine
  always_comb begin
    case (st)
      ST_IDLE: next_st = busReq ? ST_DONE : ST_IDLE;
      ST_DONE: next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  // read mux
  always_comb begin
    rdWord = '0;
    case (1'b1)
      hitFlags: rdWord = {16'h0000, TAG_FLAGS, 2'b00, flags};
      hitLow:   rdWord = {16'h0000, TAG_LOW, lowField};
      hitHigh:  rdWord = {16'h0000, TAG_HIGH, highField};
      hitCfg:   rdWord = {16'h0000, TAG_CFG, 2'b00, laneSel, 4'h0, oorEn, 3'b000};
      hitIrqSt: rdWord = {29'h0000_000, irqStat};
      hitIrqMk: rdWord = {29'h0000_000, irqMask};
      default:  rdWord = '0;
    endcase
  end

  wire alertAny = |flags[7:0];
  wire routeOor = (laneSel == LANE_ONE) && oorEn;

  // bus answer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st      <= ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      st      <= next_st;
      pready  <= next_st == ST_DONE;
      pslverr <= busReq && !mapped;
      prdata  <= (busReq && !pwrite) ? rdWord : '0;
    end
  end

  // read snapshot of the flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flagSnap <= FLAGS_RST;
    end else if (busReq && hitFlags && !pwrite) begin
      flagSnap <= flags;
    end
  end

  // flags and interrupt status
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags   <= FLAGS_RST;
      irqStat <= '0;
      irq     <= 1'b0;
    end else begin
      flags   <= next_flags;
      irqStat <= next_irqStat;
      irq     <= |(next_irqStat & irqMask);
    end
  end

  // limit registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lowField  <= LOW_RST;
      highField <= HIGH_RST;
    end else if (hardHit) begin
      lowField  <= LOW_RST;
      highField <= HIGH_RST;
    end else begin
      if (wrLow) lowField <= pwdata[LIM_W-1:0];
      if (wrHigh) highField <= pwdata[LIM_W-1:0];
    end
  end

  // configuration and mask
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      laneSel <= LANE_RST;
      oorEn   <= OOR_EN_RST;
      irqMask <= '0;
    end else if (hardHit) begin
      laneSel <= LANE_RST;
      oorEn   <= OOR_EN_RST;
    end else begin
      if (wrCfg) laneSel <= pwdata[CFG_LANE_LO+1:CFG_LANE_LO];
      if (wrCfg) oorEn <= pwdata[CFG_OOR_EN];
      if (wrIrqMk) irqMask <= pwdata[IRQ_W-1:0];
    end
  end

  // pins and command pulses
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      secondDataOut  <= 1'b0;
      softResetPulse <= 1'b0;
      setupRestart   <= 1'b0;
    end else begin
      secondDataOut  <= routeOor ? alertAny : laneBData;
      softResetPulse <= softHit || hardHit;
      setupRestart   <= hardHit;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_flag_read;
    rdFlags ##0 (setBits == '0);
  endsequence

  sequence s_soft_cmd;
    softHit ##0 !crcWriteFail ##0 (alertSet == '0);
  endsequence

  crc_flag_set_a: assert property (crcWriteFail |=> flags[FL_CRC])
    else $error("write check flag not set");
  setup_flag_set_a: assert property (setupLoadFail |=> flags[FL_SETUP])
    else $error("load failure flag not set");
  setup_flag_hold_a: assert property (
    flags[FL_SETUP] && !hardHit |=> flags[FL_SETUP])
    else $error("load failure flag cleared without hard reset");
  over_flag_set_a: assert property (
    hitValid && hitOver[0] |=> flags[1])
    else $error("over flag of channel a not set");
  under_flag_set_a: assert property (
    hitValid && hitUnder[3] |=> flags[6])
    else $error("under flag of channel d not set");
  read_clears_a: assert property (
    s_flag_read |=> (flags[7:0] & $past(flagSnap[7:0])) == '0 ##1 !pready)
    else $error("read did not clear reported flags");
  flags_sticky_a: assert property (
    flags[0] && !rdFlags && !softHit && !hardHit |=> flags[0])
    else $error("channel flag dropped without a read");
  addr_nibble_a: assert property (
    busReq && hitFlags && !pwrite |=> prdata[15:12] == TAG_FLAGS && pready)
    else $error("flag register address nibble wrong");
  limit_fill_a: assert property (
    lowInt[3:0] == LOW_FILL && highInt[3:0] == HIGH_FILL)
    else $error("limit fill bits wrong");
  soft_clear_a: assert property (
    s_soft_cmd |=> flags[FL_CRC] == 1'b0 && flags[7:0] == '0 && $stable(highField))
    else $error("soft reset did not clear flags only");
  hard_default_a: assert property (
    hardHit |=> highField == HIGH_RST && lowField == LOW_RST ##1 !setupRestart)
    else $error("hard reset left register contents");
  second_lane_a: assert property (
    routeOor && !wrCfg && !hardHit |=> secondDataOut == $past(alertAny))
    else $error("alert not routed to second data output");
  set_wins_a: assert property (
    rdFlags && crcWriteFail |=> flags[FL_CRC])
    else $error("flag event lost under clearing read");

  // bus answer, channel, reset command and interrupt checks
  pready_pulse_a: assert property (
    pready |=> !pready)
    else $error("bus answer held longer than one cycle");
  bad_addr_a: assert property (
    busReq && !mapped |=> pready && pslverr)
    else $error("unmapped access not flagged");
  idle_data_a: assert property (
    !pready |-> prdata == '0)
    else $error("read data not zero outside answer");
  chan_wins_a: assert property (
    rdFlags && alertSet[0] |=> flags[0])
    else $error("channel event lost under clearing read");
  soft_keeps_a: assert property (
    softHit |=> $stable(lowField) && $stable(laneSel) && $stable(oorEn))
    else $error("soft reset changed register contents");
  hard_clear_a: assert property (
    hardHit && !setupLoadFail |=> setupRestart && !flags[FL_SETUP])
    else $error("hard reset kept load failure flag");
  over_b_a: assert property (
    hitValid && hitOver[1] |=> flags[3])
    else $error("over flag of channel b not set");
  irq_level_a: assert property (
    (irqStat & irqMask) != '0 && !wrIrqSt && !wrIrqMk |=> irq)
    else $error("interrupt low with unmasked status");
  w1c_clear_a: assert property (
    wrIrqSt && pwdata[EV_ALERT] && !irqEvt[EV_ALERT] |=> !irqStat[EV_ALERT])
    else $error("status bit not cleared by write one");
endmodule

// ==== dv/oor_src_model.sv ====
// oor_src_model: conversion result and fault event source
`timescale 1ns/1ps
module oor_src_model (
  input  wire logic         clk_sys,
  output oor_pkg::oor_conv_t conv,
  output logic              crcWriteFail,
  output logic              setupLoadFail
);
  import oor_pkg::*;
  initial begin
    conv = '0;
    crcWriteFail = 1'b0;
    setupLoadFail = 1'b0;
  end
  // one result set for channels a to d, valid for one cycle
  task automatic send(input oor_res_t a, input oor_res_t b, input oor_res_t c, input oor_res_t d);
    @(posedge clk_sys);
    conv.valid <= 1'b1;
    conv.value <= {d, c, b, a};
    @(posedge clk_sys);
    conv.valid <= 1'b0;
    conv.value <= ~{d, c, b, a};
  endtask
  // one-cycle crc or load failure event
  task automatic fault(input logic crc);
    @(posedge clk_sys);
    crcWriteFail <= crc;
    setupLoadFail <= ~crc;
    @(posedge clk_sys);
    crcWriteFail <= 1'b0;
    setupLoadFail <= 1'b0;
  endtask
endmodule

// ==== dv/tb.sv ====
// tb: register level tests of the out-of-range monitor
`timescale 1ns/1ps
module tb;
  import oor_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst_b = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [ADDR_W-1:0]  paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  oor_conv_t          conv;
  logic               crcWriteFail;
  logic               setupLoadFail;
  logic               laneBData = 1'b0;
  logic               secondDataOut;
  logic               irq;
  logic               softResetPulse;
  logic               setupRestart;
  int                 softCnt = 0;
  int                 restartCnt = 0;
  localparam int      PIN_IRQ = 0;
  localparam int      PIN_SDO = 1;
  logic               lastErr;
  logic [31:0]        rdVal;
  int                 mismatches = 0;
  int                 numChecks = 0;

  always #5 clk_sys = ~clk_sys;

  // command pulse counters
  always @(posedge clk_sys) begin
    if (softResetPulse === 1'b1) softCnt++;
    if (setupRestart === 1'b1) restartCnt++;
  end

  oor_src_model src (.clk_sys(clk_sys), .conv(conv), .crcWriteFail(crcWriteFail),
    .setupLoadFail(setupLoadFail));

  oor_monitor dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv(conv), .crcWriteFail(crcWriteFail),
    .setupLoadFail(setupLoadFail), .laneBData(laneBData), .secondDataOut(secondDataOut),
    .softResetPulse(softResetPulse), .setupRestart(setupRestart), .irq(irq));

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // apb transfer: setup, access held until pready sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      summarize();
    end
    rdVal = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rdVal);
  endtask

  task automatic pin(input string n, input logic e, input int sel);
    repeat (3) @(posedge clk_sys);
    chk(n, {31'h0, e}, {31'h0, (sel == PIN_IRQ) ? irq : secondDataOut});
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(OFS_HIGH, 32'h0000_5FFF, "upper rst");
    rdc(OFS_LOW, 32'h0000_4000, "lower rst");
    rdc(OFS_FLAGS, 32'h0000_3000, "flags rst");
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, lastErr});
    wr(OFS_FLAGS, 32'h0000_FFFF);
    rdc(OFS_FLAGS, 32'h0000_3000, "flags ro");
    wr(OFS_LOW, 32'h0000_0100);
    wr(OFS_HIGH, 32'h0000_0200);
    rdc(OFS_HIGH, 32'h0000_5200, "upper");
    src.send(16'h0FFF, 16'h1000, 16'h200F, 16'h2010);
    rdc(OFS_FLAGS, 32'h0000_3081, "edges");
    src.send(16'h2010, 16'h0000, 16'h1001, 16'hFFFF);
    rdc(OFS_FLAGS, 32'h0000_3086, "mixed");
    rdc(OFS_FLAGS, 32'h0000_3000, "cleared");
    src.fault(1'b1);
    rdc(OFS_FLAGS, 32'h0000_3200, "crc set");
    rdc(OFS_FLAGS, 32'h0000_3000, "crc clr");
    // crc event lands on the completion edge of a clearing read
    fork
      rdc(OFS_FLAGS, 32'h0000_3000, "race read");
      begin
        repeat (2) @(posedge clk_sys);
        src.fault(1'b1);
      end
    join
    rdc(OFS_FLAGS, 32'h0000_3200, "race kept");
    wr(OFS_IRQ_ST, 32'h0000_0007);
    wr(OFS_IRQ_MSK, 32'h0000_0001);
    src.send(16'h2010, 16'h1800, 16'h1800, 16'h1800);
    pin("irq set", 1'b1, PIN_IRQ);
    wr(OFS_IRQ_ST, 32'h0000_0001);
    pin("irq clr", 1'b0, PIN_IRQ);
    wr(OFS_CFG, 32'h0000_0108);
    rdc(OFS_CFG, 32'h0000_2108, "cfg");
    pin("alert out", 1'b1, PIN_SDO);
    src.fault(1'b0);
    rdc(OFS_FLAGS, 32'h0000_3102, "load set");
    rdc(OFS_FLAGS, 32'h0000_3100, "load kept");
    pin("alert off", 1'b0, PIN_SDO);
    src.send(16'h2010, 16'h1800, 16'h1800, 16'h1800);
    wr(OFS_CMD, {24'h0, CMD_SOFT});
    rdc(OFS_FLAGS, 32'h0000_3100, "soft flags");
    rdc(OFS_HIGH, 32'h0000_5200, "soft upper");
    chk("soft pulses", 32'h0000_0001, softCnt);
    wr(OFS_CMD, {24'h0, CMD_HARD});
    rdc(OFS_FLAGS, 32'h0000_3000, "hard flags");
    rdc(OFS_HIGH, 32'h0000_5FFF, "hard upper");
    rdc(OFS_LOW, 32'h0000_4000, "hard lower");
    rdc(OFS_CFG, 32'h0000_2000, "hard cfg");
    chk("hard pulses", 32'h0000_0002, softCnt);
    chk("restarts", 32'h0000_0001, restartCnt);
    laneBData <= 1'b1;
    pin("lane data", 1'b1, PIN_SDO);
    wr(OFS_CFG, 32'h0000_0208);
    pin("en ignored", 1'b1, PIN_SDO);
    wr(OFS_IRQ_ST, 32'h0000_0007);
    wr(OFS_IRQ_MSK, 32'h0000_0000);
    wr(OFS_LOW, 32'h0000_0100);
    src.send(16'h0FFF, 16'h8000, 16'h8000, 16'h8000);
    pin("irq masked", 1'b0, PIN_IRQ);
    rdc(OFS_IRQ_ST, 32'h0000_0001, "irq status");
    summarize();
  end
endmodule
